// >>> rtl/tcpa_pkg.sv
// Shared constants and carriers for the timer and pulse accumulator block
package tcpa_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SYS = 6'h00;
  localparam logic [5:0] IDX_CHCFG = 6'h01;
  localparam logic [5:0] IDX_OUTCTL = 6'h02;
  localparam logic [5:0] IDX_FORCE = 6'h03;
  localparam logic [5:0] IDX_CHFLG = 6'h04;
  localparam logic [5:0] IDX_FREE_RUNNING_COUNTER = 6'h05;
  localparam logic [5:0] IDX_VAL0 = 6'h08;
  localparam logic [5:0] IDX_CTL = 6'h20;
  localparam logic [5:0] IDX_FLG = 6'h21;
  localparam logic [5:0] IDX_CNT = 6'h22;
  // System control fields
  localparam int SYS_TEN = 7;
  localparam int SYS_FFCA = 4;
  localparam int SYS_COUNTER_RESET_ENABLE = 3;
  // Accumulator control fields
  localparam int CTL_EN = 6;
  localparam int CTL_MODE = 5;
  localparam int CTL_EDGE = 4;
  localparam int CTL_CLK = 2;
  localparam int CTL_OVI = 1;
  localparam int CTL_PAI = 0;
  // Accumulator flag fields
  localparam int FLG_OVF = 1;
  localparam int FLG_EDGE = 0;
  // Output control field positions
  localparam int OUT_MASK = 8;
  localparam int OUT_DATA = 12;
  localparam int OUT_PORT = 16;
  localparam int OUT_DIR = 20;
  // Channel config field positions
  localparam int CFG_IE = 4;
  localparam int CFG_EDGE = 8;
  // Counter clock selections
  localparam logic [1:0] CLK_PRE = 2'h0;
  localparam logic [1:0] CLK_ACC = 2'h1;
  localparam logic [1:0] CLK_ACC256 = 2'h2;
  // Divide-by-64 tap of the prescaler counter
  localparam logic [5:0] DIV64_TAP = 6'h3f;
  localparam logic [7:0] DIV256_TAP = 8'hff;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } tcpa_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcpa_axi_rsp_t;
endpackage

// >>> rtl/tcpa_top.sv
// Timer with four capture/compare channels and pulse accumulator
//
// Behaviour
// [R1] Mode/edge bits pick edge count or gated
// [R2] Clock select picks prescaler, acc, /256, /65536
// [R3] Overflow flag sets on count rollover
// [R4] Edge flag sets on event or gate end
// [R5] Fast clear: count access clears flags
// [R6] Count accessed as one 16-bit word
// [R7] Accumulator input synchronised before counting
// [R8] Prescaler divides by one to 128
// [R9] Capture copies counter, sets channel flag
// [R10] Capture pulses exceed two bus clocks
// [R11] Compare match drives pin, sets flag
// [R12] Mode and level zero disconnects pin
// [R13] Force compare acts without setting flag
// [R14] Channel 7 compare overrides masked pins
// [R15] Channel 7 compare may reset counter
// [R16] Counter cycles zero to channel 7 value
// [R17] Port writes latch without moving pin
// [R18] Accumulator pulses exceed two bus clocks
// [R19] Edge counting works with timer off
// [R20] Gated mode needs the divide-by-64 clock
// [R21] Enables gate accumulator interrupt requests
// [R22] Software frees channel 7 before counting
// [R23] Accumulator off forces prescaler clock
// [R24] Clock select change acts immediately
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tcpa_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire tcpa_pkg::tcpa_axi_req_t axi_req,
  output tcpa_pkg::tcpa_axi_rsp_t axi_rsp,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [3:0] chan_irq,
  output logic acc_overflow_irq,
  output logic acc_edge_irq
);
  import tcpa_pkg::*;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [1:0] sy_fill;
    logic [6:0] pre;
    logic [15:0] free_running_counter;
    logic cnt_new;
    logic [15:0] acc_div;
    logic [15:0] pulse_acc_count;
    logic [1:0] pulse_acc_flags;
    logic [6:0] ctl;
    logic [7:0] sys;
    logic [3:0] chan_direction_select;
    logic [3:0] chan_irq_enable;
    logic [3:0] cap_edge;
    logic [7:0] mode_level;
    logic [3:0] mask7;
    logic [3:0] data7;
    logic [3:0] port_latch;
    logic [3:0] port_dir;
    logic [3:0][15:0] chan_value_reg;
    logic [3:0] chan_event_flag;
    logic [3:0] cmp_q;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] chan_irq;
    logic ovf_irq;
    logic edge_irq;
    logic aw_held;
    logic [7:0] awa;
    logic w_held;
    logic [31:0] wd;
    logic [3:0] ws;
    tcpa_axi_rsp_t rsp;
  } tcpa_state_t;

  localparam tcpa_state_t RST = '0;

  tcpa_state_t s;
  tcpa_state_t next_s;
  logic [3:0] rise, fall, hit, force_v, cap_ev;
  logic [6:0] pmask;
  logic pre_tick, d64, acc_clk, acc_edge_ev, tick, cr_rst;
  logic do_wr, do_rd, cnt_access, rd_ok, wr_ok;
  logic [31:0] wmask, rd_val;

  // Register read mux; unmapped or misaligned gives an error
  function automatic logic [32:0] rd_mux(input tcpa_state_t st,
                                         input logic [7:0] a);
    logic [31:0] v;
    logic ok;
    v = 32'h0;
    ok = (a[1:0] == 2'h0);
    case (a[7:2])
      IDX_SYS: v[7:0] = st.sys;
      IDX_CHCFG: v[11:0] = {st.cap_edge, st.chan_irq_enable,
                            st.chan_direction_select};
      IDX_OUTCTL: v[23:0] = {st.port_dir, st.port_latch, st.data7,
                             st.mask7, st.mode_level};
      IDX_FORCE: v = 32'h0;
      IDX_CHFLG: v[3:0] = st.chan_event_flag;
      IDX_FREE_RUNNING_COUNTER: v[15:0] = st.free_running_counter;
      IDX_VAL0, IDX_VAL0 + 6'h1, IDX_VAL0 + 6'h2, IDX_VAL0 + 6'h3:
        v[15:0] = st.chan_value_reg[a[3:2]];
      IDX_CTL: v[6:0] = st.ctl;
      IDX_FLG: v[1:0] = st.pulse_acc_flags;
      IDX_CNT: v[15:0] = st.pulse_acc_count;
      default: ok = 1'b0;
    endcase
    return {ok, ok ? v : 32'h0};
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    // Two-flop synchroniser; edges wait for three real samples [R7]
    next_s.sy1 = pin_in;
    next_s.sy2 = s.sy1;
    next_s.sy3 = s.sy2;
    next_s.sy_fill = (s.sy_fill == 2'h3) ? 2'h3 : s.sy_fill + 2'h1;
    rise = s.sy2 & ~s.sy3 & {4{s.sy_fill == 2'h3}};
    fall = ~s.sy2 & s.sy3 & {4{s.sy_fill == 2'h3}};

    // Prescaler runs only while the timer is enabled [R8]
    next_s.pre = s.sys[SYS_TEN] ? s.pre + 7'h01 : 7'h00;
    pmask = (7'h01 << s.sys[2:0]) - 7'h01;
    pre_tick = s.sys[SYS_TEN] & ((s.pre & pmask) == pmask); // [R8]
    // No divide-by-64 clock without the timer [R20]
    d64 = s.sys[SYS_TEN] & (s.pre[5:0] == DIV64_TAP);

    // Accumulator clock: active edge, or gated divide-by-64 [R1] [R19]
    acc_edge_ev = s.ctl[CTL_EN] &
                  (s.ctl[CTL_EDGE] ? rise[3] : fall[3]); // [R4]
    if (s.ctl[CTL_MODE]) begin
      acc_clk = s.ctl[CTL_EN] & d64 &
                (s.ctl[CTL_EDGE] ? ~s.sy2[3] : s.sy2[3]); // [R1] [R20]
    end else begin
      acc_clk = acc_edge_ev; // [R19]
    end

    // Counter clock chosen live from the select bits [R2] [R23] [R24]
    if (!s.ctl[CTL_EN]) begin
      tick = pre_tick; // [R23]
    end else begin
      unique case (s.ctl[CTL_CLK+:2])
        CLK_PRE: tick = pre_tick;
        CLK_ACC: tick = acc_clk;
        CLK_ACC256: tick = acc_clk & (s.acc_div[7:0] == DIV256_TAP);
        default: tick = acc_clk & (s.acc_div == COUNT_TOP);
      endcase
    end
    tick = tick & s.sys[SYS_TEN];

    // Compare matches fire once, on the cycle after the counter moves
    hit = s.chan_direction_select &
          {s.chan_value_reg[3] == s.free_running_counter,
           s.chan_value_reg[2] == s.free_running_counter,
           s.chan_value_reg[1] == s.free_running_counter,
           s.chan_value_reg[0] == s.free_running_counter} &
          {4{s.cnt_new}};
    cap_ev = ~s.chan_direction_select &
             ((s.cap_edge & fall) | (~s.cap_edge & rise));
    cr_rst = s.sys[SYS_COUNTER_RESET_ENABLE] & hit[3] &
             (s.chan_value_reg[3] != 16'h0); // [R15] [R16]

    // Bus side: write runs once address and data are both held
    do_wr = s.aw_held & s.w_held & ~s.rsp.bvalid;
    do_rd = s.rsp.arready & axi_req.arvalid;
    wmask = {{8{s.ws[3]}}, {8{s.ws[2]}}, {8{s.ws[1]}}, {8{s.ws[0]}}};
    {rd_ok, rd_val} = rd_mux(s, axi_req.araddr);
    wr_ok = rd_mux(s, s.awa) >> 32 != 33'h0;
    force_v = 4'h0;
    cnt_access = (do_wr & (s.awa[7:2] == IDX_CNT)) |
                 (do_rd & (axi_req.araddr[7:2] == IDX_CNT));

    if (s.rsp.awready & axi_req.awvalid) begin
      next_s.aw_held = 1'b1;
      next_s.awa = axi_req.awaddr;
    end
    if (s.rsp.wready & axi_req.wvalid) begin
      next_s.w_held = 1'b1;
      next_s.wd = axi_req.wdata;
      next_s.ws = axi_req.wstrb;
    end
    if (s.rsp.bvalid & axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_ok) begin
        case (s.awa[7:2])
          IDX_SYS: next_s.sys = (s.sys & ~wmask[7:0]) |
              (s.wd[7:0] & wmask[7:0]);
          IDX_CHCFG: {next_s.cap_edge, next_s.chan_irq_enable,
                      next_s.chan_direction_select} =
              ({s.cap_edge, s.chan_irq_enable, s.chan_direction_select}
               & ~wmask[11:0]) | (s.wd[11:0] & wmask[11:0]);
          // Port bits only reach the pin through the latch [R17]
          IDX_OUTCTL: {next_s.port_dir, next_s.port_latch, next_s.data7,
                       next_s.mask7, next_s.mode_level} =
              ({s.port_dir, s.port_latch, s.data7, s.mask7, s.mode_level}
               & ~wmask[23:0]) | (s.wd[23:0] & wmask[23:0]); // [R17]
          IDX_FORCE: force_v = s.wd[3:0] & wmask[3:0]; // [R13]
          IDX_CHFLG: next_s.chan_event_flag =
              s.chan_event_flag & ~(s.wd[3:0] & wmask[3:0]);
          IDX_CTL: next_s.ctl = (s.ctl & ~wmask[6:0]) |
              (s.wd[6:0] & wmask[6:0]);
          // Write-one-to-clear accumulator flags [R3] [R4]
          IDX_FLG: next_s.pulse_acc_flags =
              s.pulse_acc_flags & ~(s.wd[1:0] & wmask[1:0]);
          // Whole word in one beat; partial lanes keep other byte [R6]
          IDX_CNT: next_s.pulse_acc_count = (s.pulse_acc_count &
              ~wmask[15:0]) | (s.wd[15:0] & wmask[15:0]); // [R6]
          IDX_FREE_RUNNING_COUNTER: ;
          default: begin
            // Value writes ignored on capture channels
            if (s.chan_direction_select[s.awa[3:2]]) begin
              next_s.chan_value_reg[s.awa[3:2]] =
                  (s.chan_value_reg[s.awa[3:2]] & ~wmask[15:0]) |
                  (s.wd[15:0] & wmask[15:0]);
            end
          end
        endcase
      end
    end
    // Read data latched at the address handshake
    if (do_rd) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = rd_val;
      next_s.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rsp.rvalid & axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (cnt_access & s.sys[SYS_FFCA]) begin
      next_s.pulse_acc_flags = 2'h0; // [R5]
    end

    // Accumulator counting; events set flags after any clear
    if (acc_clk) begin
      next_s.pulse_acc_count = s.pulse_acc_count + 16'h1;
      next_s.acc_div = s.acc_div + 16'h1;
      if (s.pulse_acc_count == COUNT_TOP) begin
        next_s.pulse_acc_flags[FLG_OVF] = 1'b1; // [R3]
      end
    end
    if (acc_edge_ev) begin
      next_s.pulse_acc_flags[FLG_EDGE] = 1'b1; // [R4]
    end

    // Counter: channel 7 reset wins over the clock tick
    next_s.cnt_new = 1'b0;
    if (cr_rst) begin
      next_s.free_running_counter = 16'h0; // [R15] [R16]
      next_s.cnt_new = 1'b1;
    end else if (tick) begin
      next_s.free_running_counter = s.free_running_counter + 16'h1;
      next_s.cnt_new = 1'b1;
    end

    // Per channel capture and compare actions
    for (int k = 0; k < 4; k++) begin
      if (cap_ev[k]) begin
        next_s.chan_value_reg[k] = s.free_running_counter; // [R9]
        next_s.chan_event_flag[k] = 1'b1; // [R9]
      end
      if (s.chan_direction_select[k] & (hit[k] | force_v[k])) begin
        unique case (s.mode_level[2*k+:2])
          2'h1: next_s.cmp_q[k] = ~s.cmp_q[k]; // [R11]
          2'h2: next_s.cmp_q[k] = 1'b0; // [R11]
          2'h3: next_s.cmp_q[k] = 1'b1; // [R11] [R13]
          default: ;
        endcase
      end
      if (hit[k]) begin
        next_s.chan_event_flag[k] = 1'b1; // [R11]
      end
      // Channel 7 overrides every masked compare pin [R14]
      if ((hit[3] | force_v[3]) & s.mask7[k]) begin
        next_s.cmp_q[k] = s.data7[k]; // [R14]
      end
    end

    // Pin drive: compare logic when connected, else port latch
    for (int k = 0; k < 4; k++) begin
      if (next_s.chan_direction_select[k] &
          ((next_s.mode_level[2*k+:2] != 2'h0) | next_s.mask7[k])) begin
        next_s.pin_oe[k] = 1'b1;
        next_s.pin_out[k] = next_s.cmp_q[k];
      end else begin
        next_s.pin_oe[k] = next_s.port_dir[k]; // [R12] [R17]
        next_s.pin_out[k] = next_s.port_latch[k];
      end
    end

    // Interrupt request levels gated by their enables [R21]
    next_s.chan_irq = next_s.chan_event_flag & next_s.chan_irq_enable;
    next_s.ovf_irq = next_s.pulse_acc_flags[FLG_OVF] & next_s.ctl[CTL_OVI];
    next_s.edge_irq = next_s.pulse_acc_flags[FLG_EDGE] & next_s.ctl[CTL_PAI];
    // Each write ready only while its own beat is not held and no response waits, so one write in flight
    next_s.rsp.awready = ~next_s.aw_held & ~next_s.rsp.bvalid;
    next_s.rsp.wready = ~next_s.w_held & ~next_s.rsp.bvalid;
    next_s.rsp.arready = ~next_s.rsp.rvalid;
  end

  // State register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST;
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp = s.rsp;
  assign pin_out = s.pin_out;
  assign pin_oe = s.pin_oe;
  assign chan_irq = s.chan_irq;
  assign acc_overflow_irq = s.ovf_irq;
  assign acc_edge_irq = s.edge_irq;

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_edge_count: assert property ( // [R1]
    acc_clk && !cnt_access && !do_wr |=>
    s.pulse_acc_count == $past(s.pulse_acc_count) + 16'h1)
    else $error("accumulator did not advance on its clock");
  chk_ovf_set: assert property ( // [R3]
    acc_clk && s.pulse_acc_count == COUNT_TOP |=>
    s.pulse_acc_flags[FLG_OVF])
    else $error("overflow flag missed rollover");
  chk_edge_flag: assert property ( // [R4]
    s.ctl[CTL_EN] && !s.ctl[CTL_EDGE] && $fell(s.sy2[3]) |=>
    s.pulse_acc_flags[FLG_EDGE])
    else $error("edge flag not set");
  chk_fast_clear: assert property ( // [R5]
    cnt_access && s.sys[SYS_FFCA] && !acc_clk && !acc_edge_ev |=>
    s.pulse_acc_flags == 2'h0)
    else $error("fast clear left a flag set");
  chk_capture_val: assert property ( // [R9]
    cap_ev[0] |=> s.chan_value_reg[0] == $past(s.free_running_counter)
    && s.chan_event_flag[0])
    else $error("capture did not store counter");
  chk_force_flag: assert property ( // [R13]
    force_v[1] && !hit[1] && !s.chan_event_flag[1] && !cap_ev[1] |=>
    !s.chan_event_flag[1])
    else $error("forced compare set the flag");
  chk_counter_wrap: assert property ( // [R16]
    cr_rst |=> s.free_running_counter == 16'h0 ##1
    s.free_running_counter != $past(s.chan_value_reg[3]) || !s.cnt_new)
    else $error("counter did not wrap at channel 7 value");
  chk_disconnect: assert property ( // [R12]
    ##1 !s.chan_direction_select[2] |-> s.pin_oe[2] == s.port_dir[2]
    && s.pin_out[2] == s.port_latch[2])
    else $error("free pin not driven from port latch");
  chk_gated_stop: assert property ( // [R20]
    s.ctl[CTL_MODE] && !s.sys[SYS_TEN] && !cnt_access && !do_wr |=>
    $stable(s.pulse_acc_count))
    else $error("gated count moved with timer off");
  chk_pre_off: assert property ( // [R23]
    !s.ctl[CTL_EN] && !s.sys[SYS_TEN] && !cr_rst |=>
    $stable(s.free_running_counter))
    else $error("counter ran without prescaler clock");

  cov_capture: cover property (cap_ev[0] ##1 s.chan_irq[0]);
  cov_wrap: cover property (cr_rst ##1 s.cnt_new);
  cov_overflow: cover property (acc_clk && s.pulse_acc_count == COUNT_TOP);
  cov_force: cover property (force_v != 4'h0);
endmodule
`default_nettype wire

// >>> sim/tcpa_pin_model.sv
// Far-side model: external drivers on the four channel pins
`timescale 1ns/10ps
`default_nettype none
module tcpa_pin_model (
  input wire logic aclk,
  input wire logic [3:0] ext_level,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in
);
  logic [3:0] line = 4'hf;
  logic [1:0] held = 2'h3;
  // Each level stands four clocks at least; narrow pulses are stretched to four clocks or lost
  always_ff @(posedge aclk) begin
    if (ext_level != line && held == 2'h3) begin
      line <= ext_level;
      held <= 2'h0;
    end else if (held != 2'h3) begin
      held <= held + 2'h1;
    end
  end
  // Block drive wins where enabled, else the external level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & line);
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the timer and pulse accumulator block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tcpa_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  tcpa_axi_req_t req = '0;
  tcpa_axi_rsp_t rsp;
  logic [3:0] ext = 4'hf;
  logic [3:0] pin_in, pin_out, pin_oe, chan_irq;
  logic ovf_irq, edge_irq;
  logic [31:0] rd, t1, t2, top;
  logic [1:0] resp;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;

  tcpa_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .chan_irq(chan_irq), .acc_overflow_irq(ovf_irq),
    .acc_edge_irq(edge_irq));
  tcpa_pin_model far (.aclk(aclk), .ext_level(ext), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in));

  // 40 ns period
  initial forever #20 aclk = ~aclk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard; the whole run needs far fewer cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected %0t timeout", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Write address and data offered together, each released when taken
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    req.awaddr <= {i, 2'h0};
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && rsp.awready) begin
        a = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!rsp.bvalid);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rdr(input logic [5:0] i);
    @(posedge aclk);
    req.araddr <= {i, 2'h0};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge aclk);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Level change, then time for the model and the synchroniser
  task automatic drive(input int ch, input logic lvl);
    @(posedge aclk);
    ext[ch] <= lvl;
    repeat (10) @(posedge aclk);
  endtask

  task automatic pulse3();
    drive(3, 1'b0);
    drive(3, 1'b1);
  endtask

  task automatic t_bus();
    rdr(6'h30);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped resp");
    chk(rd, 32'h0, "unmapped data");
    $display("test bus done");
  endtask

  task automatic t_edges();
    wr(IDX_SYS, 32'h0);
    wr(IDX_OUTCTL, 32'h0);
    wr(IDX_CTL, 32'h41);
    wr(IDX_CNT, 32'h0);
    wr(IDX_FLG, 32'h3);
    repeat (3) pulse3();
    rdr(IDX_CNT);
    chk(rd, 32'h3, "falling count");
    rdr(IDX_FLG);
    chk(rd, 32'h1, "edge flag");
    chk({31'h0, edge_irq}, 32'h1, "edge irq");
    wr(IDX_CTL, 32'h50);
    drive(3, 1'b0);
    rdr(IDX_CNT);
    chk(rd, 32'h3, "no rise yet");
    drive(3, 1'b1);
    rdr(IDX_CNT);
    chk(rd, 32'h4, "rising count");
    $display("test edges done");
  endtask

  task automatic t_overflow();
    wr(IDX_CTL, 32'h42);
    wr(IDX_CNT, 32'hffff);
    wr(IDX_FLG, 32'h3);
    pulse3();
    rdr(IDX_CNT);
    chk(rd, 32'h0, "rollover");
    chk({31'h0, ovf_irq}, 32'h1, "ovf irq");
    wr(IDX_FLG, 32'h0);
    rdr(IDX_FLG);
    chk(rd, 32'h3, "zero write keeps");
    wr(IDX_FLG, 32'h2);
    rdr(IDX_FLG);
    chk(rd, 32'h1, "one write clears");
    wr(IDX_SYS, 32'h10);
    rdr(IDX_CNT);
    rdr(IDX_FLG);
    chk(rd, 32'h0, "fast clear");
    $display("test overflow done");
  endtask

  task automatic t_gated();
    wr(IDX_SYS, 32'h0);
    wr(IDX_CTL, 32'h60);
    wr(IDX_CNT, 32'h0);
    wr(IDX_FLG, 32'h3);
    repeat (200) @(posedge aclk);
    rdr(IDX_CNT);
    chk(rd, 32'h0, "gate timer off");
    wr(IDX_SYS, 32'h80);
    repeat (640) @(posedge aclk);
    wr(IDX_SYS, 32'h0);
    rdr(IDX_CNT);
    chk({31'h0, rd >= 9 && rd <= 11}, 32'h1, "gated count");
    drive(3, 1'b0);
    rdr(IDX_FLG);
    chk(rd, 32'h1, "gate trailing");
    drive(3, 1'b1);
    $display("test gated done");
  endtask

  task automatic t_capture();
    wr(IDX_CTL, 32'h0);
    wr(IDX_SYS, 32'h80);
    wr(IDX_CHCFG, 32'h10);
    drive(0, 1'b0);
    wr(IDX_CHFLG, 32'hf);
    rdr(IDX_FREE_RUNNING_COUNTER);
    t1 = rd;
    drive(0, 1'b1);
    rdr(IDX_FREE_RUNNING_COUNTER);
    t2 = rd;
    rdr(IDX_VAL0);
    chk({31'h0, rd >= t1 && rd <= t2}, 32'h1, "captured");
    rdr(IDX_CHFLG);
    chk(rd, 32'h1, "capture flag");
    chk({28'h0, chan_irq}, 32'h1, "capture irq");
    $display("test capture done");
  endtask

  task automatic t_compare();
    wr(IDX_SYS, 32'h0);
    wr(IDX_CHCFG, 32'h2);
    wr(IDX_CHFLG, 32'hf);
    wr(IDX_OUTCTL, 32'h22000c);
    wr(IDX_FORCE, 32'h2);
    chk({30'h0, pin_oe[1], pin_out[1]}, 32'h3, "force set");
    wr(IDX_OUTCTL, 32'h220008);
    wr(IDX_FORCE, 32'h2);
    chk({31'h0, pin_out[1]}, 32'h0, "latch kept off");
    rdr(IDX_CHFLG);
    chk(rd, 32'h0, "force no flag");
    wr(IDX_OUTCTL, 32'h220000);
    chk({31'h0, pin_out[1]}, 32'h1, "latch shown");
    $display("test compare done");
  endtask

  // Mid-run reset brings the counter to zero; channel 7 then bounds it
  task automatic t_reset_cycle();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wr(IDX_CHCFG, 32'h8a);
    wr(IDX_VAL0 + 6'h3, 32'ha);
    wr(IDX_OUTCTL, 32'h2200);
    wr(IDX_CHFLG, 32'hf);
    wr(IDX_SYS, 32'h88);
    top = 32'h0;
    repeat (20) begin
      rdr(IDX_FREE_RUNNING_COUNTER);
      if (rd > top) top = rd;
    end
    chk(top, 32'ha, "count top");
    chk({30'h0, pin_oe[1], pin_out[1]}, 32'h3, "ch7 mask drive");
    rdr(IDX_CHFLG);
    chk(rd & 32'h8, 32'h8, "ch7 flag");
    chk({31'h0, chan_irq[3]}, 32'h1, "ch7 irq");
    $display("test reset cycle done");
  endtask

  task automatic t_clock_sel();
    wr(IDX_SYS, 32'h80);
    wr(IDX_CHCFG, 32'h0);
    wr(IDX_CTL, 32'h44);
    rdr(IDX_FREE_RUNNING_COUNTER);
    t1 = rd;
    repeat (3) pulse3();
    rdr(IDX_FREE_RUNNING_COUNTER);
    chk(rd - t1, 32'h3, "acc clock");
    wr(IDX_CTL, 32'h48);
    rdr(IDX_FREE_RUNNING_COUNTER);
    t1 = rd;
    pulse3();
    rdr(IDX_FREE_RUNNING_COUNTER);
    chk(rd - t1, 32'h0, "acc div 256");
    wr(IDX_CTL, 32'h04);
    rdr(IDX_FREE_RUNNING_COUNTER);
    t1 = rd;
    repeat (40) @(posedge aclk);
    rdr(IDX_FREE_RUNNING_COUNTER);
    chk({31'h0, rd - t1 > 40}, 32'h1, "acc off");
    wr(IDX_SYS, 32'h83);
    rdr(IDX_FREE_RUNNING_COUNTER);
    t1 = rd;
    repeat (80) @(posedge aclk);
    rdr(IDX_FREE_RUNNING_COUNTER);
    t2 = rd - t1;
    chk({31'h0, t2 >= 10 && t2 <= 12}, 32'h1, "divide 8");
    $display("test clock select done");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_edges();
    t_overflow();
    t_gated();
    t_capture();
    t_compare();
    t_reset_cycle();
    t_clock_sel();
    stop_test();
  end
endmodule
`default_nettype wire
